// ### src/cpms_pkg.sv
package cpms_pkg;
   // =========================================================
   // host interface modes
   typedef enum logic [1:0] {
      CPMS_MUX_PAR = 2'h0,
      CPMS_NONMUX_PAR = 2'h1,
      CPMS_SERIAL = 2'h2,
      CPMS_HW = 2'h3
   } cpms_mode_e;

   // =========================================================
   // shared port pin positions
   localparam int CPMS_PORT_W = 8;
   localparam int CPMS_BIT_RX_TERM = 7;
   localparam int CPMS_BIT_TX_TERM = 6;
   localparam int CPMS_BIT_RX_OP1 = 5;
   localparam int CPMS_BIT_RX_OP0 = 4;
   localparam int CPMS_BIT_TX_SYNC = 3;
   localparam int CPMS_BIT_SCLK = 2;
   localparam int CPMS_BIT_MOSI = 1;
   localparam int CPMS_BIT_MISO = 0;

   // =========================================================
   // mux parallel: address phase on the shared pins
   localparam logic CPMS_PHASE_ADDR = 1'h1;
   localparam logic [7:0] CPMS_BYTE_ZERO = 8'h00;

   // =========================================================
   // configuration defaults restored by the reset pin edge
   localparam logic CPMS_CFG_OFF = 1'h0;
   localparam logic [1:0] CPMS_OP_DEFAULT = 2'h0;
endpackage : cpms_pkg

// ### src/cpms_if.sv
`timescale 1ns/100ps
interface cpms_if;
   // shared port pins, each side drives with its own enable
   logic [7:0] dev_port_o;
   logic [7:0] dev_port_oe;
   logic [7:0] host_port_o;
   logic [7:0] host_port_oe;
   // interrupt / jitter clock select (open drain)
   logic dev_int_oe;
   logic host_jack_o;
   logic host_jack_oe;
   // straps and control
   logic [1:0] host_if_select;
   logic reset_hiz_pin;
   logic tx_op_sel_b1;
   logic tx_op_sel_b2;
   logic cpol_strap;
   logic cpha_strap;
   logic [7:0] port_level;
   logic int_level;
   // resolved wire levels, pull-ups assumed
   assign port_level = (dev_port_o & dev_port_oe) | (host_port_o & host_port_oe)
                       | ~(dev_port_oe | host_port_oe);
   assign int_level = ~dev_int_oe & ~(host_jack_oe & ~host_jack_o);
   modport device (
      output dev_port_o, dev_port_oe, dev_int_oe,
      input port_level, int_level, host_if_select, reset_hiz_pin,
      input tx_op_sel_b1, tx_op_sel_b2, cpol_strap, cpha_strap
   );
   modport host (
      output host_port_o, host_port_oe, host_jack_o, host_jack_oe,
      output host_if_select, reset_hiz_pin, tx_op_sel_b1, tx_op_sel_b2,
      output cpol_strap, cpha_strap,
      input port_level, int_level
   );
endinterface : cpms_if

// ### src/cpms_host.sv
`timescale 1ns/100ps
module cpms_host
   import cpms_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // user side settings
   input wire cpms_pkg::cpms_mode_e i_mode,
   input wire logic i_hold_reset,
   input wire logic i_jack_t1,
   input wire logic [7:0] i_strap,
   input wire logic [1:0] i_tx_op,
   input wire logic i_cpol,
   input wire logic i_cpha,
   // user side data
   input wire logic i_drive,
   input wire logic i_addr_phase,
   input wire logic [7:0] i_data,
   output logic [7:0] o_rd_data,
   output logic o_int_b,
   // link
   cpms_if.host link
);
   import cpms_pkg::*;

   typedef struct packed {
      logic [7:0] port_o;
      logic [7:0] port_oe;
      logic jack_o;
      logic rst_pin;
      logic [7:0] rd_data;
      logic int_b;
   } cpms_host_s;

   cpms_host_s r;
   cpms_host_s next_r;

   // =========================================================
   // next state
   always_comb begin
      next_r = r;
      next_r.rst_pin = i_hold_reset; // see RQ5
      next_r.rd_data = link.port_level;
      next_r.int_b = link.int_level;
      next_r.jack_o = i_jack_t1; // see RQ2
      next_r.port_o = CPMS_BYTE_ZERO;
      next_r.port_oe = CPMS_BYTE_ZERO;
      case (i_mode)
         CPMS_HW: begin
            next_r.port_o = i_strap;
            next_r.port_oe = ~CPMS_BYTE_ZERO;
         end
         CPMS_SERIAL: begin
            next_r.port_o = i_data;
            next_r.port_oe = ~CPMS_BYTE_ZERO;
            next_r.port_oe[CPMS_BIT_MISO] = 1'b0; // see RQ15
         end
         CPMS_MUX_PAR: begin
            next_r.port_o = i_data;
            next_r.port_oe = {CPMS_PORT_W{i_drive | i_addr_phase}}; // see RQ8
         end
         CPMS_NONMUX_PAR: begin
            next_r.port_o = i_data;
            next_r.port_oe = {CPMS_PORT_W{i_drive}}; // see RQ7
         end
         default: begin
            next_r.port_oe = CPMS_BYTE_ZERO;
         end
      endcase
   end

   // =========================================================
   // state register
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         r <= '0;
         r.int_b <= 1'b1;
         r.jack_o <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign link.host_port_o = r.port_o;
   assign link.host_port_oe = r.port_oe;
   assign link.host_jack_o = r.jack_o;
   assign link.host_jack_oe = (i_mode == CPMS_HW);
   assign link.host_if_select = i_mode;
   assign link.reset_hiz_pin = r.rst_pin;
   assign link.tx_op_sel_b1 = i_tx_op[0];
   assign link.tx_op_sel_b2 = i_tx_op[1];
   // address pins double as these straps; unused and held low in multiplexed mode
   assign link.cpol_strap = i_cpol & (i_mode != CPMS_MUX_PAR); // see RQ17 see RQ18
   assign link.cpha_strap = i_cpha & (i_mode != CPMS_MUX_PAR); // see RQ18
   assign o_rd_data = r.rd_data;
   assign o_int_b = r.int_b;
endmodule : cpms_host

// ### src/cpms_device.sv
`timescale 1ns/100ps
// Notes on behaviour
// RQ1: interrupt pulls low while status needs service
// RQ2: board straps jitter clock high for T1
// RQ3: reset pin rising edge restores register defaults
// RQ4: reset pin high floats all outputs
// RQ5: host holds reset pin low normally
// RQ6: select 00 mux,01 nonmux,10 serial,11 hardware
// RQ7: select 01 gives plain eight-bit data bus
// RQ8: select 00 gives multiplexed address and data
// RQ9: hardware mode rx term strap disables termination
// RQ10: hardware mode tx term strap disables termination
// RQ11: hardware mode rx mode from port straps
// RQ12: hardware mode tx mode from dedicated straps
// RQ13: strap chooses tx sync pin function
// RQ14: strap chooses rx sync pin function
// RQ15: serial mode one pin is serial clock
// RQ16: serial mode lowest pin drives read data
// RQ17: serial mode address straps set clock polarity/phase
// RQ18: mux mode upper address pins tied low
// RQ19: hardware mode never drives shared pins
// RQ20: interrupt released after reset until enabled event
module cpms_device
   import cpms_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // core side
   input wire logic i_status_irq,
   input wire logic i_rd_en,
   input wire logic [7:0] i_rd_data,
   input wire logic i_miso,
   // decoded configuration
   output cpms_pkg::cpms_mode_e o_mode,
   output logic o_cfg_reset,
   output logic o_hiz,
   output logic o_rx_term_off,
   output logic o_tx_term_off,
   output logic [1:0] o_rx_op,
   output logic [1:0] o_tx_op,
   output logic o_tx_sync_sel,
   output logic o_rx_sync_sel,
   output logic o_jack_sel,
   output logic o_sclk,
   output logic o_mosi,
   output logic o_cpol,
   output logic o_cpha,
   output logic o_addr_phase,
   output logic [7:0] o_port_in,
   // link
   cpms_if.device link
);
   import cpms_pkg::*;

   // =========================================================
   // registered state
   typedef struct packed {
      // decoded mode and reset pin history
      cpms_mode_e mode;
      logic rst_pin_d;
      logic cfg_reset;
      logic hiz;
      // configuration taken from straps, held outside hardware mode
      logic rx_term_off;
      logic tx_term_off;
      logic [1:0] rx_op;
      logic [1:0] tx_op;
      logic tx_sync_sel;
      logic rx_sync_sel;
      logic jack_sel;
      // serial port sampling
      logic sclk;
      logic mosi;
      logic cpol;
      logic cpha;
      // shared pin sampling and drive
      logic addr_phase;
      logic [7:0] port_in;
      logic [7:0] port_o;
      logic [7:0] port_oe;
      logic int_oe;
   } cpms_dev_s;

   cpms_dev_s r;
   cpms_dev_s next_r;
   // hardware mode: shared pins are straps and only ever read
   logic hw;

   // =========================================================
   // configuration defaults, restored on the reset pin edge
   function automatic cpms_dev_s clear_cfg(input cpms_dev_s cur);
      cpms_dev_s res;
      res = cur;
      res.rx_term_off = CPMS_CFG_OFF;
      res.tx_term_off = CPMS_CFG_OFF;
      res.rx_op = CPMS_OP_DEFAULT;
      res.tx_op = CPMS_OP_DEFAULT;
      res.tx_sync_sel = CPMS_CFG_OFF;
      res.rx_sync_sel = CPMS_CFG_OFF;
      res.jack_sel = CPMS_CFG_OFF;
      res.cpol = CPMS_CFG_OFF;
      res.cpha = CPMS_CFG_OFF;
      return res;
   endfunction : clear_cfg

   // =========================================================
   // next state
   always_comb begin
      next_r = r;
      hw = (link.host_if_select == CPMS_HW);
      // mode and reset pin history follow the pins every cycle
      next_r.mode = cpms_mode_e'(link.host_if_select); // see RQ6
      next_r.rst_pin_d = link.reset_hiz_pin;
      next_r.cfg_reset = link.reset_hiz_pin & ~r.rst_pin_d; // see RQ3
      next_r.hiz = link.reset_hiz_pin; // see RQ4
      next_r.port_in = link.port_level;
      // idle: nothing is driven unless the mode below asks for it
      next_r.addr_phase = 1'b0;
      next_r.sclk = 1'b0;
      next_r.mosi = 1'b0;
      next_r.port_o = CPMS_BYTE_ZERO;
      next_r.port_oe = CPMS_BYTE_ZERO;

      if (hw) begin // see RQ19
         // port enables stay low here so the board strap levels are never disturbed
         next_r.rx_term_off = link.port_level[CPMS_BIT_RX_TERM]; // see RQ9
         next_r.tx_term_off = link.port_level[CPMS_BIT_TX_TERM]; // see RQ10
         next_r.rx_op = {link.port_level[CPMS_BIT_RX_OP1],
                         link.port_level[CPMS_BIT_RX_OP0]}; // see RQ11
         next_r.tx_op = {link.tx_op_sel_b2, link.tx_op_sel_b1}; // see RQ12
         next_r.tx_sync_sel = link.port_level[CPMS_BIT_TX_SYNC]; // see RQ13
         next_r.rx_sync_sel = link.port_level[CPMS_BIT_SCLK]; // see RQ14
         next_r.jack_sel = link.int_level;
      end else begin
         case (cpms_mode_e'(link.host_if_select))
            CPMS_SERIAL: begin
               // pin levels only; shifting belongs to the serial engine
               next_r.sclk = link.port_level[CPMS_BIT_SCLK]; // see RQ15
               next_r.mosi = link.port_level[CPMS_BIT_MOSI];
               next_r.cpol = link.cpol_strap; // see RQ17
               next_r.cpha = link.cpha_strap;
               next_r.port_o[CPMS_BIT_MISO] = i_miso; // see RQ16
               next_r.port_oe[CPMS_BIT_MISO] = i_rd_en;
            end
            CPMS_MUX_PAR: begin
               // no read pending: the host owns the pins for an address
               next_r.addr_phase = ~i_rd_en & CPMS_PHASE_ADDR; // see RQ8
               next_r.port_o = i_rd_data;
               next_r.port_oe = {CPMS_PORT_W{i_rd_en}};
            end
            CPMS_NONMUX_PAR: begin
               next_r.port_o = i_rd_data; // see RQ7
               next_r.port_oe = {CPMS_PORT_W{i_rd_en}};
            end
            default: begin
               next_r.port_oe = CPMS_BYTE_ZERO;
            end
         endcase
      end

      // open drain interrupt, never in hardware mode where the pin is a strap
      next_r.int_oe = i_status_irq & ~hw; // see RQ1 see RQ20

      // floating outranks every mode, the interrupt included
      if (link.reset_hiz_pin) begin
         next_r.port_oe = CPMS_BYTE_ZERO; // see RQ4
         next_r.int_oe = 1'b0;
      end

      // defaults win over a strap latched in the same cycle
      if (next_r.cfg_reset) begin
         next_r = clear_cfg(next_r); // see RQ3
      end
   end

   // =========================================================
   // state register
   // asynchronous reset clears every field, so no pin is driven
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // =========================================================
   // pin and core outputs
   assign link.dev_port_o = r.port_o;
   assign link.dev_port_oe = r.port_oe;
   assign link.dev_int_oe = r.int_oe;
   assign o_mode = r.mode;
   assign o_cfg_reset = r.cfg_reset;
   assign o_hiz = r.hiz;
   assign o_rx_term_off = r.rx_term_off;
   assign o_tx_term_off = r.tx_term_off;
   assign o_rx_op = r.rx_op;
   assign o_tx_op = r.tx_op;
   assign o_tx_sync_sel = r.tx_sync_sel;
   assign o_rx_sync_sel = r.rx_sync_sel;
   assign o_jack_sel = r.jack_sel;
   assign o_sclk = r.sclk;
   assign o_mosi = r.mosi;
   assign o_cpol = r.cpol;
   assign o_cpha = r.cpha;
   assign o_addr_phase = r.addr_phase;
   assign o_port_in = r.port_in;
endmodule : cpms_device

// ### bench/cpms_properties.sv
`timescale 1ns/100ps
module cpms_properties (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // device drive
   input wire logic [7:0] dev_port_oe,
   input wire logic dev_int_oe,
   // host straps
   input wire logic [1:0] host_if_select,
   input wire logic reset_hiz_pin,
   // address straps
   input wire logic cpol_strap,
   input wire logic cpha_strap
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_b);
   // =========================================================
   // pin drive rules
   a_int_release: assert property ($rose(i_rst_b) |-> !dev_int_oe)
      else $error("interrupt pulled at reset exit");
   a_hiz_port: assert property (reset_hiz_pin |=> dev_port_oe == 8'h00)
      else $error("port driven while floating");
   a_hiz_int: assert property (reset_hiz_pin [*2] |-> !dev_int_oe)
      else $error("interrupt pulled while floating");
   a_hw_port: assert property (host_if_select == 2'h3 |=> dev_port_oe == 8'h00)
      else $error("port driven in hardware mode");
   a_hw_int: assert property (host_if_select == 2'h3 |=> !dev_int_oe)
      else $error("interrupt pulled in hardware mode");
   a_serial_pins: assert property (host_if_select == 2'h2 |=>
      dev_port_oe[7:1] == 7'h00)
      else $error("serial mode drives input pins");
   a_nonmux_byte: assert property (host_if_select == 2'h1 |=>
      dev_port_oe inside {8'h00, 8'hff})
      else $error("partial byte drive in nonmux mode");
   a_mux_byte: assert property (host_if_select == 2'h0 |=>
      dev_port_oe inside {8'h00, 8'hff})
      else $error("partial byte drive in mux mode");
   a_mux_addr_low: assert property (host_if_select == 2'h0 |->
      !cpol_strap && !cpha_strap)
      else $error("address straps not low in mux mode");
   c_hw: cover property (host_if_select == 2'h3 ##1 host_if_select == 2'h3);
   c_float: cover property (reset_hiz_pin [*2]);
   c_read: cover property (dev_port_oe == 8'hff);
endmodule : cpms_properties

// ### bench/testbench.sv
`timescale 1ns/100ps
module testbench;
   import cpms_pkg::*;
   logic i_clk, i_rst_b, i_hold_reset, i_jack_t1, i_cpol, i_cpha, i_drive, i_addr_phase;
   logic i_status_irq, i_rd_en, i_miso, o_int_b, o_cfg_reset, o_hiz, o_rx_term_off;
   logic o_tx_term_off, o_tx_sync_sel, o_rx_sync_sel, o_jack_sel, o_sclk, o_mosi;
   logic o_cpol, o_cpha, o_addr_phase;
   logic [7:0] i_strap, i_data, i_rd_data, o_rd_data, o_port_in;
   logic [1:0] i_tx_op, o_rx_op, o_tx_op;
   cpms_mode_e i_mode, o_mode;
   int miscompares = 0;
   int num_checks = 0;
   cpms_if link ();
   cpms_host u_cpms_host (.i_clk, .i_rst_b, .i_mode, .i_hold_reset, .i_jack_t1, .i_strap,
      .i_tx_op, .i_cpol, .i_cpha, .i_drive, .i_addr_phase, .i_data, .o_rd_data, .o_int_b,
      .link);
   cpms_device u_cpms_device (.i_clk, .i_rst_b, .i_status_irq, .i_rd_en, .i_rd_data, .i_miso,
      .o_mode, .o_cfg_reset, .o_hiz, .o_rx_term_off, .o_tx_term_off, .o_rx_op, .o_tx_op,
      .o_tx_sync_sel, .o_rx_sync_sel, .o_jack_sel, .o_sclk, .o_mosi, .o_cpol, .o_cpha,
      .o_addr_phase, .o_port_in, .link);
   cpms_properties u_cpms_properties (.i_clk, .i_rst_b, .dev_port_oe(link.dev_port_oe),
      .dev_int_oe(link.dev_int_oe), .host_if_select(link.host_if_select),
      .reset_hiz_pin(link.reset_hiz_pin), .cpol_strap(link.cpol_strap),
      .cpha_strap(link.cpha_strap));
   // =========================================================
   // helpers
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wt(input int n);
      repeat (n) @(negedge i_clk);
   endtask : wt
   // straps follow the host data so hardware mode sees them on the port
   task automatic drv(input cpms_mode_e m, input logic dr, input logic [7:0] d,
                      input logic rd, input logic [7:0] rdd, input int n);
      i_mode = m;
      i_drive = dr;
      i_data = d;
      i_strap = d;
      i_rd_en = rd;
      i_rd_data = rdd;
      wt(n);
   endtask : drv
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : print_verdict
   // =========================================================
   // scenarios
   task automatic t_modes;
      for (int m = 0; m < 4; m++) begin
         drv(cpms_mode_e'(m), 0, 8'h00, 0, 8'h00, 1);
         chk("mode", o_mode, 8'(m));
      end
      $display("test modes done");
   endtask : t_modes
   task automatic t_nonmux;
      drv(CPMS_NONMUX_PAR, 0, 8'h00, 1, 8'ha5, 2);
      chk("rd_data", o_rd_data, 8'ha5);
      drv(CPMS_NONMUX_PAR, 1, 8'h3c, 0, 8'h00, 2);
      chk("port_in", o_port_in, 8'h3c);
      i_status_irq = 1;
      drv(CPMS_NONMUX_PAR, 0, 8'h00, 0, 8'h00, 2);
      chk("int_b", o_int_b, 1'b0);
      i_status_irq = 0;
      wt(2);
      chk("int_b", o_int_b, 1'b1);
      $display("test nonmux done");
   endtask : t_nonmux
   task automatic t_mux;
      i_cpol = 1;
      i_addr_phase = 1;
      drv(CPMS_MUX_PAR, 1, 8'h5a, 0, 8'h00, 2);
      chk("port_in", o_port_in, 8'h5a);
      chk("addr_phase", o_addr_phase, 1'b1);
      i_addr_phase = 0;
      drv(CPMS_MUX_PAR, 0, 8'h00, 1, 8'hc3, 2);
      chk("rd_data", o_rd_data, 8'hc3);
      chk("addr_phase", o_addr_phase, 1'b0);
      $display("test mux done");
   endtask : t_mux
   task automatic t_serial;
      i_cpol = 1;
      drv(CPMS_SERIAL, 0, 8'h00, 1, 8'h00, 2);
      chk("rd_data", o_rd_data, 8'h00);
      chk("cpol", o_cpol, 1'b1);
      chk("cpha", o_cpha, 1'b0);
      i_miso = 1;
      drv(CPMS_SERIAL, 1, 8'h06, 1, 8'h00, 2);
      chk("rd_data", o_rd_data, 8'h07);
      chk("sclk", o_sclk, 1'b1);
      chk("mosi", o_mosi, 1'b1);
      $display("test serial done");
   endtask : t_serial
   task automatic t_hw;
      i_tx_op = 2'h2;
      i_jack_t1 = 1;
      i_status_irq = 1;
      drv(CPMS_HW, 1, 8'hb8, 1, 8'h00, 2);
      chk("rx_term_off", o_rx_term_off, 1'b1);
      chk("tx_term_off", o_tx_term_off, 1'b0);
      chk("rx_op", o_rx_op, 2'h3);
      chk("tx_op", o_tx_op, 2'h2);
      chk("tx_sync_sel", o_tx_sync_sel, 1'b1);
      chk("rx_sync_sel", o_rx_sync_sel, 1'b0);
      chk("jack_sel", o_jack_sel, 1'b1);
      chk("rd_data", o_rd_data, 8'hb8);
      chk("int_b", o_int_b, 1'b1);
      i_status_irq = 0;
      $display("test hardware done");
   endtask : t_hw
   task automatic t_reset_pin;
      int n;
      n = 0;
      i_hold_reset = 1;
      drv(CPMS_NONMUX_PAR, 0, 8'h00, 1, 8'h81, 0);
      for (int k = 0; k < 4; k++) begin
         wt(1);
         n += int'(o_cfg_reset);
      end
      chk("cfg_reset", 8'(n), 8'h01);
      chk("rx_term_off", o_rx_term_off, 1'b0);
      chk("hiz", o_hiz, 1'b1);
      chk("rd_data", o_rd_data, 8'hff);
      i_hold_reset = 0;
      wt(3);
      chk("hiz", o_hiz, 1'b0);
      chk("rd_data", o_rd_data, 8'h81);
      $display("test reset pin done");
   endtask : t_reset_pin
   // =========================================================
   // clock, watchdog and main sequence
   initial begin
      i_clk = 0;
      forever #2.5 i_clk = ~i_clk;
   end
   initial begin
      repeat (1000) @(posedge i_clk);
      miscompares++;
      print_verdict();
   end
   initial begin
      i_rst_b = 0;
      i_hold_reset = 0;
      i_jack_t1 = 0;
      i_cpol = 0;
      i_cpha = 0;
      i_addr_phase = 0;
      i_tx_op = 2'h0;
      i_status_irq = 0;
      i_miso = 0;
      drv(CPMS_NONMUX_PAR, 0, 8'h00, 0, 8'h00, 16);
      i_rst_b = 1;
      wt(1);
      chk("int_b", o_int_b, 1'b1);
      t_modes();
      t_nonmux();
      t_mux();
      t_serial();
      t_hw();
      t_reset_pin();
      print_verdict();
   end
endmodule : testbench
